/* src/card_detect_pkg.sv */
// Shared constants and types for the card hot-plug detection block
package card_detect_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int DEBOUNCE_US = 10;
    // Stable time rounds up to whole cycles
    localparam int DEBOUNCE_CYCLES = (DEBOUNCE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEB_W = 12;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic HOT_PLUG_RESET = 1'b1;
    localparam logic POLARITY_RESET = 1'b1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_BOOT = 3'b000,
        ST_EMPTY = 3'b001,
        ST_INIT = 3'b010,
        ST_REGISTER = 3'b011,
        ST_READY = 3'b100
    } card_state_type;

    typedef struct packed {
        logic init_start;
        logic reg_start;
        logic card_access_en;
        logic card_inserted;
    } card_status_type;

endpackage

/* src/presence_debounce.sv */
// Synchroniser and debounce filter for the card-presence input
`timescale 1ns/10ps
`default_nettype none

module presence_debounce (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic raw_in,
    output logic stable_out,
    output logic stable_valid
);

    logic sync1_q;
    logic sync2_q;
    logic stable_q, stable_d;
    logic valid_q, valid_d;
    logic [card_detect_pkg::DEB_W-1:0] cnt_q, cnt_d;

    always_comb begin
        stable_d = stable_q;
        valid_d = valid_q;
        cnt_d = cnt_q;
        if (sync2_q == stable_q && valid_q) begin
            cnt_d = '0;
        end else if (cnt_q == card_detect_pkg::DEB_W'(card_detect_pkg::DEBOUNCE_CYCLES - 1)) begin
            stable_d = sync2_q;
            valid_d = 1'b1;
            cnt_d = '0;
        end else if (!valid_q && sync2_q != stable_q) begin
            // Level changed while qualifying the first value: restart
            stable_d = sync2_q;
            cnt_d = '0;
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            stable_q <= 1'b0;
            valid_q <= 1'b0;
            cnt_q <= '0;
        end else begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
            stable_q <= stable_d;
            valid_q <= valid_d;
            cnt_q <= cnt_d;
        end
    end

    assign stable_out = stable_q;
    assign stable_valid = valid_q;

endmodule

`default_nettype wire

/* src/card_hot_plug_detect.sv */
// Card hot-plug detection: presence tracking, polarity and card start-up sequencing
`timescale 1ns/10ps
`default_nettype none

// Operation
// RULE1 - At default polarity a high presence level means a card is inserted.
// RULE2 - Hot-plug detection is on after reset; enable 1 keeps presence tracking alive.
// RULE3 - With enable 0 the card is read once at power-on, input ignored after.
// RULE4 - Enabled and presence active: recognise insertion, start card initialisation.
// RULE5 - After card information is read successfully, start network registration.
// RULE6 - Enabled and presence inactive: card removed, stop all card accesses.
// RULE7 - Polarity 1 (default) is active high; polarity 0 makes low mean present.
// RULE8 - Boards without a detect switch leave the presence input floating.
// RULE9 - Presence input is synchronised and debounced before any decision.
module card_hot_plug_detect (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic card_present_in,
    input wire logic hot_plug_enable_setting,
    input wire logic presence_polarity_setting,
    input wire logic card_read_done,
    output logic init_start,
    output logic reg_start,
    output logic card_access_en,
    output logic card_inserted
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_s1_q;
    logic rst_n_q;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // ------------------------------------------------------------
    // Presence conditioning
    // ------------------------------------------------------------
    logic pres_level;
    logic pres_valid;

    presence_debounce u_debounce (
        .ref_clk(ref_clk),
        .rst_n(rst_n_q),
        .raw_in(card_present_in),
        .stable_out(pres_level),
        .stable_valid(pres_valid)
    ); // RULE9

    // Polarity 1 passes the level, 0 inverts it
    // Applied after the filter, so a live flip reads as an edge: change it only under reset
    logic present;
    assign present = pres_level ~^ presence_polarity_setting; // RULE1 RULE7

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    card_detect_pkg::card_state_type state_q, state_d;
    card_detect_pkg::card_status_type stat_q, stat_d;
    logic booted_q, booted_d;

    always_comb begin
        state_d = state_q;
        booted_d = booted_q;
        stat_d = '0;
        unique case (state_q)
            card_detect_pkg::ST_BOOT: begin
                if (pres_valid) begin
                    booted_d = 1'b1;
                    // Disabled detection reads the card once regardless of the input
                    if (!hot_plug_enable_setting || present) begin // RULE3 RULE4
                        state_d = card_detect_pkg::ST_INIT;
                        stat_d.init_start = 1'b1;
                    end else begin
                        state_d = card_detect_pkg::ST_EMPTY;
                    end
                end
            end
            card_detect_pkg::ST_EMPTY: begin
                if (hot_plug_enable_setting && present) begin // RULE2 RULE4
                    state_d = card_detect_pkg::ST_INIT;
                    stat_d.init_start = 1'b1;
                end
            end
            card_detect_pkg::ST_INIT: begin
                if (card_read_done) begin // RULE5
                    state_d = card_detect_pkg::ST_REGISTER;
                    stat_d.reg_start = 1'b1;
                end
            end
            card_detect_pkg::ST_REGISTER: begin
                state_d = card_detect_pkg::ST_READY;
            end
            card_detect_pkg::ST_READY: begin
                state_d = card_detect_pkg::ST_READY;
            end
            default: begin
                state_d = card_detect_pkg::ST_BOOT;
            end
        endcase
        // Removal overrides every card state except ST_BOOT while tracking is on
        if (hot_plug_enable_setting && booted_q && !present
            && state_q != card_detect_pkg::ST_BOOT) begin // RULE6
            state_d = card_detect_pkg::ST_EMPTY;
            stat_d.init_start = 1'b0;
            stat_d.reg_start = 1'b0;
        end
        stat_d.card_access_en = (state_d == card_detect_pkg::ST_INIT)
            || (state_d == card_detect_pkg::ST_REGISTER)
            || (state_d == card_detect_pkg::ST_READY);
        stat_d.card_inserted = stat_d.card_access_en;
    end

    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= card_detect_pkg::ST_BOOT;
            stat_q <= '0;
            booted_q <= 1'b0;
        end else begin
            state_q <= state_d;
            stat_q <= stat_d;
            booted_q <= booted_d;
        end
    end

    assign init_start = stat_q.init_start;
    assign reg_start = stat_q.reg_start;
    assign card_access_en = stat_q.card_access_en;
    assign card_inserted = stat_q.card_inserted;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_removal_stops_access: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // RULE6
        (hot_plug_enable_setting && booted_q && !present && state_q != card_detect_pkg::ST_BOOT)
        |=> !card_access_en) else $error("access not stopped on removal");

    a_insert_starts_init: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // RULE4
        (state_q == card_detect_pkg::ST_EMPTY && hot_plug_enable_setting && present)
        |=> init_start && card_access_en) else $error("insertion missed");

    a_read_starts_reg: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // RULE5
        (state_q == card_detect_pkg::ST_INIT && card_read_done
        && !(hot_plug_enable_setting && !present))
        |=> reg_start ##1 !reg_start) else $error("registration not started");

    a_disabled_holds: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // RULE3
        (!hot_plug_enable_setting && state_q == card_detect_pkg::ST_READY)
        |=> card_access_en) else $error("card dropped while detection off");

    a_boot_disabled_reads: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // RULE3
        (state_q == card_detect_pkg::ST_BOOT && pres_valid && !hot_plug_enable_setting)
        |=> init_start) else $error("power-on read missing");

    // Filtered level equal to the polarity setting must count as a card
    a_polarity_map: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // RULE1 RULE7
        (state_q == card_detect_pkg::ST_EMPTY && hot_plug_enable_setting
        && (pres_level == presence_polarity_setting)) |=> init_start)
        else $error("polarity mapping wrong");

    a_reg_after_init: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // RULE5
        $rose(reg_start) |-> $past(state_q) == card_detect_pkg::ST_INIT)
        else $error("registration without init");

    a_no_init_when_absent: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // RULE2
        (hot_plug_enable_setting && booted_q && !present) |=> !init_start)
        else $error("init while absent");

endmodule

`default_nettype wire

/* test/card_switch_model.sv */
// Behavioural detect switch of the card connector
`timescale 1ns/10ps
`default_nettype none

module card_switch_model (
    input wire logic card,
    input wire logic polarity,
    input wire logic has_switch,
    output wire logic level
);
    // The board strap sets which level a seated card gives; no switch leaves the pin open
    assign level = has_switch ? ~(card ^ polarity) : 1'bz;
endmodule
`default_nettype wire

/* test/card_hot_plug_detect_tb.sv */
// Self-checking bench for the card hot-plug detection block
`timescale 1ns/10ps
`default_nettype none

module card_hot_plug_detect_tb;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic card = 1'b0;
    logic en = 1'b1;
    logic pol = 1'b1;
    logic done = 1'b0;
    wire logic pin;
    card_detect_pkg::card_status_type st;
    int failures = 0;
    int n_checks = 0;

    always #2 ref_clk = ~ref_clk;

    card_switch_model sw (.card(card), .polarity(pol), .has_switch(1'b1), .level(pin));

    card_hot_plug_detect uut (.ref_clk(ref_clk), .arst_n(arst_n), .card_present_in(pin),
        .hot_plug_enable_setting(en), .presence_polarity_setting(pol),
        .card_read_done(done), .init_start(st.init_start), .reg_start(st.reg_start),
        .card_access_en(st.card_access_en), .card_inserted(st.card_inserted));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic final_report();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Status order: init_start, reg_start, card_access_en, card_inserted
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic hold(input int n, input logic [3:0] exp);
        repeat (n) begin
            @(negedge ref_clk);
            check(st, exp);
        end
    endtask

    // Waits for the next status change, which must land within n cycles
    task automatic wait_for(input int n, input logic [3:0] exp);
        int i;
        logic [3:0] prev;
        prev = st;
        for (i = 0; i < n && st === prev; i++) @(negedge ref_clk);
        if (st === prev) begin
            failures++;
            final_report();
        end else begin
            check(st, exp);
        end
    endtask

    // Settings change only under reset, so the filter restarts from the new pin level
    task automatic do_reset(input logic e, input logic p);
        @(negedge ref_clk);
        arst_n = 1'b0;
        en = e;
        pol = p;
        repeat (5) @(negedge ref_clk);
        arst_n = 1'b1;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_idle();
        hold(3000, 4'h0);
    endtask

    // Bounce shorter than the filter time must not start anything
    task automatic t_insert();
        repeat (3) begin
            card = 1'b1;
            hold(800, 4'h0);
            card = 1'b0;
            hold(50, 4'h0);
        end
        card = 1'b1;
        wait_for(2600, 4'hb);
        hold(1, 4'h3);
        done = 1'b1;
        wait_for(2, 4'h7);
        done = 1'b0;
        hold(20, 4'h3);
    endtask

    task automatic t_remove();
        card = 1'b0;
        wait_for(2600, 4'h0);
        hold(3000, 4'h0);
    endtask

    // Low polarity: a high pin now means no card
    task automatic t_polarity();
        do_reset(1'b1, 1'b0);
        hold(3000, 4'h0);
        card = 1'b1;
        wait_for(2600, 4'hb);
        hold(1, 4'h3);
        card = 1'b0;
        wait_for(2600, 4'h0);
    endtask

    // Disabled tracking reads once at power-on and ignores the pin after
    task automatic t_disabled();
        do_reset(1'b0, 1'b1);
        wait_for(2700, 4'hb);
        hold(1, 4'h3);
        done = 1'b1;
        wait_for(2, 4'h7);
        done = 1'b0;
        card = 1'b1;
        hold(3000, 4'h3);
        card = 1'b0;
        hold(3000, 4'h3);
    endtask

    initial begin
        do_reset(1'b1, 1'b1);
        t_idle();
        t_insert();
        t_remove();
        t_polarity();
        t_disabled();
        final_report();
    end
endmodule
`default_nettype wire
